// ### core/cid_core.sv
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps

// What this block does
// (RULE_01) register increment adds one to working register 0-7, 8-bit wrap, 1 cycle, carry updated.
// (RULE_02) indirect increment bumps the data byte pointed at by register 0 or 1, carry updated.
// (RULE_03) long increment adds one to 16-bit pair 0 or 1 in one cycle and touches no flag.
// (RULE_04) port input loads the accumulator from the parallel port in two cycles.
// (RULE_05) receive input copies the receive buffer to the accumulator and clears receive-full.
// (RULE_06) bit-test jump loads pc low byte if accumulator bit b is one, else pc plus two.
// (RULE_07) jump on carry set loads pc low byte when carry is one, else pc plus two.
// (RULE_08) jump on user flag a goes in-page when that flag is one, else skips two bytes.
// (RULE_09) jump on user flag b goes in-page when that flag is one, else skips two bytes.
// (RULE_10) direct jump takes pc 0-7 from the operand, pc 8-10 from opcode bits 5-7 and pc 11-12 from the bank select flag.
// (RULE_11) indirect page jump loads pc low byte from the memory byte the accumulator points at.
// (RULE_12) jump on carry clear goes in-page when carry is zero, else pc plus two.
// (RULE_13) in-page jumps keep the upper pc bits so the target stays in the current page.
module cid_core (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_port_data,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_strobe,
  output logic [7:0] o_acc,
  output logic [12:0] o_pc,
  output logic o_rx_full,
  output logic o_busy,
  input wire logic [7:0] i_axi_awaddr,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  output logic [1:0] o_axi_bresp,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  input wire logic [7:0] i_axi_araddr,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready
);
  import cid_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] wreg [0:7];
  logic [7:0] data_mem [0:63];
  logic [7:0] page_mem [0:255];
  logic carry, ufa, ufb;
  logic [1:0] bank_sel;
  logic [7:0] rx_buf;
  logic [7:0] mem_ptr;
  logic [7:0] port_meta, port_sync;
  logic [7:0] ir_opcode, ir_operand;
  logic [1:0] cyc_left;
  cid_op_t ir_op, dec_op;
  logic [1:0] dec_cycles;
  logic [12:0] dec_bytes, ir_bytes;
  logic have_aw, have_w;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= ADDR_PAGE_MEM) || (a >= ADDR_WREG_BASE && a <= ADDR_WREG_LAST);
    mapped = mapped && (a[1:0] == 2'b00);
  endfunction

  function automatic logic is_wreg(input logic [7:0] a);
    is_wreg = (a >= ADDR_WREG_BASE) && (a <= ADDR_WREG_LAST) && (a[1:0] == 2'b00);
  endfunction

  cid_decode u_decode (
    .i_opcode(w_data[7:0]),
    .o_op(dec_op),
    .o_cycles(dec_cycles),
    .o_bytes(dec_bytes)
  );

  // ----------------------------------------------------------------
  // bus write path: address and data taken in either order
  // ----------------------------------------------------------------
  logic aw_fire, w_fire, wr_go, ar_fire;
  logic [31:0] wr_val;
  assign aw_fire = i_axi_awvalid && o_axi_awready;
  assign w_fire = i_axi_wvalid && o_axi_wready;
  assign wr_go = have_aw && have_w && !o_axi_bvalid;
  assign ar_fire = i_axi_arvalid && o_axi_arready;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      o_axi_awready <= 1'b1;
      o_axi_wready <= 1'b1;
      aw_addr <= RST_BYTE;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (aw_fire) begin
        have_aw <= 1'b1;
        aw_addr <= i_axi_awaddr;
        o_axi_awready <= 1'b0;
      end else if (wr_go) begin
        have_aw <= 1'b0;
        o_axi_awready <= 1'b1;
      end
      if (w_fire) begin
        have_w <= 1'b1;
        w_data <= i_axi_wdata;
        w_strb <= i_axi_wstrb;
        o_axi_wready <= 1'b0;
      end else if (wr_go) begin
        have_w <= 1'b0;
        o_axi_wready <= 1'b1;
      end
    end
  end

  // write response, one outstanding; unmapped offsets answer slverr
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_axi_bvalid <= 1'b0;
      o_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      o_axi_bvalid <= 1'b1;
      o_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_axi_bready) begin
      o_axi_bvalid <= 1'b0;
    end
  end

  logic wr_instr, wr_flags, wr_acc, wr_pc, wr_ptr, wr_dmem, wr_pmem;
  assign wr_val = merge(32'h0000_0000, w_data, w_strb);
  assign wr_instr = wr_go && aw_addr == ADDR_INSTR;
  assign wr_flags = wr_go && aw_addr == ADDR_FLAGS;
  assign wr_acc = wr_go && aw_addr == ADDR_ACC;
  assign wr_pc = wr_go && aw_addr == ADDR_PC;
  assign wr_ptr = wr_go && aw_addr == ADDR_MEM_PTR;
  assign wr_dmem = wr_go && aw_addr == ADDR_DATA_MEM;
  assign wr_pmem = wr_go && aw_addr == ADDR_PAGE_MEM;

  // ----------------------------------------------------------------
  // port pins cross in through two flops
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port_meta <= RST_BYTE;
      port_sync <= RST_BYTE;
    end else begin
      port_meta <= i_port_data;
      port_sync <= port_meta;
    end
  end

  // ----------------------------------------------------------------
  // instruction issue: a write to the instruction word starts it,
  // ignored while one is still running
  // ----------------------------------------------------------------
  logic issue, done;
  assign issue = wr_instr && !o_busy;
  assign done = o_busy && cyc_left == CYC_ONE;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
      cyc_left <= 2'd0;
      ir_op <= CID_OP_NONE;
      ir_opcode <= RST_BYTE;
      ir_operand <= RST_BYTE;
      ir_bytes <= BYTES_ONE;
    end else if (issue) begin
      o_busy <= 1'b1;
      cyc_left <= dec_cycles; // RULE_04
      ir_op <= dec_op;
      ir_opcode <= w_data[7:0];
      ir_operand <= w_data[FLD_OPERAND +: 8];
      ir_bytes <= dec_bytes;
    end else if (done) begin
      o_busy <= 1'b0;
      cyc_left <= 2'd0;
    end else if (o_busy) begin
      cyc_left <= cyc_left - 2'd1;
    end
  end

  // ----------------------------------------------------------------
  // execute results, committed on the last cycle
  // ----------------------------------------------------------------
  logic [2:0] rsel;
  logic [8:0] inc_r, inc_ind;
  logic [15:0] pair_val, pair_inc;
  logic [7:0] ind_byte;
  logic take;
  logic [12:0] next_pc;

  assign rsel = ir_opcode[2:0];
  assign inc_r = {1'b0, wreg[rsel]} + 9'd1;
  assign ind_byte = data_mem[wreg[{2'b00, rsel[0]}][5:0]];
  assign inc_ind = {1'b0, ind_byte} + 9'd1;
  assign pair_val = {wreg[{rsel[0], 2'b01}], wreg[{rsel[0], 2'b00}]};
  assign pair_inc = pair_val + 16'd1;

  always_comb begin
    take = 1'b0;
    unique case (ir_op)
      CID_OP_JB: take = o_acc[ir_opcode[7:5]]; // RULE_06
      CID_OP_JC: take = carry; // RULE_07
      CID_OP_JNC: take = !carry; // RULE_12
      CID_OP_JUFA: take = ufa; // RULE_08
      CID_OP_JUFB: take = ufb; // RULE_09
      CID_OP_NONE, CID_OP_INC_R, CID_OP_INC_IND, CID_OP_INCL, CID_OP_IN_PORT,
      CID_OP_IN_RX, CID_OP_JMP, CID_OP_JMPP: take = 1'b0;
    endcase
  end

  // target selection; untaken jumps step over both bytes
  always_comb begin
    next_pc = o_pc + ir_bytes;
    if (take) begin
      next_pc = {o_pc[12:8], ir_operand}; // RULE_13
    end else if (ir_op == CID_OP_JMP) begin
      next_pc = {bank_sel, ir_opcode[7:5], ir_operand}; // RULE_10
    end else if (ir_op == CID_OP_JMPP) begin
      next_pc = {o_pc[12:8], page_mem[o_acc]}; // RULE_11
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pc <= RST_PC;
    end else if (done) begin
      o_pc <= next_pc;
    end else if (wr_pc) begin
      o_pc <= wr_val[12:0];
    end
  end

  // accumulator loads from port or receive buffer
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_acc <= RST_BYTE;
    end else if (done && ir_op == CID_OP_IN_PORT) begin
      o_acc <= port_sync; // RULE_04
    end else if (done && ir_op == CID_OP_IN_RX) begin
      o_acc <= rx_buf; // RULE_05
    end else if (wr_acc) begin
      o_acc <= wr_val[7:0];
    end
  end

  // flags: long increment leaves them alone, byte increments set carry
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      carry <= 1'b0;
      ufa <= 1'b0;
      ufb <= 1'b0;
      bank_sel <= RST_BANK;
    end else begin
      if (done && ir_op == CID_OP_INC_R) begin
        carry <= inc_r[8]; // RULE_01
      end else if (done && ir_op == CID_OP_INC_IND) begin
        carry <= inc_ind[8]; // RULE_02
      end else if (wr_flags) begin
        carry <= wr_val[FLD_CARRY];
      end
      if (wr_flags) begin
        ufa <= wr_val[FLD_UFA];
        ufb <= wr_val[FLD_UFB];
        bank_sel <= wr_val[FLD_BANK +: 2];
      end
    end
  end

  // working registers; a pair is the low register and the one above
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 8; i++) begin
        wreg[i] <= RST_BYTE;
      end
    end else if (done && ir_op == CID_OP_INC_R) begin
      wreg[rsel] <= inc_r[7:0]; // RULE_01
    end else if (done && ir_op == CID_OP_INCL) begin
      wreg[{rsel[0], 2'b00}] <= pair_inc[7:0]; // RULE_03
      wreg[{rsel[0], 2'b01}] <= pair_inc[15:8]; // RULE_03
    end else if (wr_go && is_wreg(aw_addr)) begin
      wreg[aw_addr[4:2]] <= wr_val[7:0];
    end
  end

  // memories hold no reset; software loads them before use
  always_ff @(posedge i_ref_clk) begin
    if (done && ir_op == CID_OP_INC_IND) begin
      data_mem[wreg[{2'b00, rsel[0]}][5:0]] <= inc_ind[7:0]; // RULE_02
    end else if (wr_dmem) begin
      data_mem[mem_ptr[5:0]] <= wr_val[7:0];
    end
    if (wr_pmem) begin
      page_mem[mem_ptr] <= wr_val[7:0];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_ptr <= RST_BYTE;
    end else if (wr_ptr) begin
      mem_ptr <= wr_val[7:0];
    end
  end

  // receive buffer; a new byte wins over the clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_buf <= RST_BYTE;
      o_rx_full <= 1'b0;
    end else if (i_rx_strobe) begin
      rx_buf <= i_rx_data;
      o_rx_full <= 1'b1;
    end else if (done && ir_op == CID_OP_IN_RX) begin
      o_rx_full <= 1'b0; // RULE_05
    end
  end

  // ----------------------------------------------------------------
  // bus read path
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (is_wreg(i_axi_araddr)) begin
      rd_val[7:0] = wreg[i_axi_araddr[4:2]];
    end else begin
      unique case (i_axi_araddr)
        ADDR_INSTR: rd_val[15:0] = {ir_operand, ir_opcode};
        ADDR_STATUS: begin
          rd_val[0] = o_busy;
          rd_val[FLD_CARRY] = carry;
          rd_val[FLD_UFA] = ufa;
          rd_val[FLD_UFB] = ufb;
          rd_val[FLD_BANK +: 2] = bank_sel;
          rd_val[FLD_RXFULL] = o_rx_full;
          rd_val[FLD_PC +: 13] = o_pc;
        end
        ADDR_FLAGS: rd_val[5:1] = {bank_sel, ufb, ufa, carry};
        ADDR_ACC: rd_val[7:0] = o_acc;
        ADDR_PC: rd_val[12:0] = o_pc;
        ADDR_RXBUF: rd_val[7:0] = rx_buf;
        ADDR_MEM_PTR: rd_val[7:0] = mem_ptr;
        ADDR_DATA_MEM: rd_val[7:0] = data_mem[mem_ptr[5:0]];
        ADDR_PAGE_MEM: rd_val[7:0] = page_mem[mem_ptr];
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_axi_arready <= 1'b1;
      o_axi_rvalid <= 1'b0;
      o_axi_rdata <= 32'h0000_0000;
      o_axi_rresp <= RESP_OKAY;
    end else if (ar_fire) begin
      o_axi_arready <= 1'b0;
      o_axi_rvalid <= 1'b1;
      o_axi_rdata <= rd_val;
      o_axi_rresp <= mapped(i_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (o_axi_rvalid && i_axi_rready) begin
      o_axi_rvalid <= 1'b0;
      o_axi_arready <= 1'b1;
    end
  end

endmodule // cid_core

// ### core/cid_decode.sv
`timescale 1ns/1ps

module cid_decode (
  input wire logic [7:0] i_opcode,
  output cid_pkg::cid_op_t o_op,
  output logic [1:0] o_cycles,
  output logic [12:0] o_bytes
);
  import cid_pkg::*;

  function automatic logic hit(input logic [7:0] op, input logic [7:0] pat,
                               input logic [7:0] msk);
    hit = ((op & msk) == pat);
  endfunction

  // ----------------------------------------------------------------
  // opcode classification, increment groups first, then exact codes, then the three-bit-field jumps
  // ----------------------------------------------------------------
  always_comb begin
    o_op = CID_OP_NONE;
    o_cycles = CYC_ONE;
    o_bytes = BYTES_ONE;
    if (hit(i_opcode, OPC_INC_R, MSK_INC_R)) begin
      o_op = CID_OP_INC_R; // RULE_01
    end else if (hit(i_opcode, OPC_INC_IND, MSK_ONE_BIT)) begin
      o_op = CID_OP_INC_IND; // RULE_02
    end else if (hit(i_opcode, OPC_INCL, MSK_ONE_BIT)) begin
      o_op = CID_OP_INCL; // RULE_03
    end else if (hit(i_opcode, OPC_IN_PORT, MSK_ALL)) begin
      o_op = CID_OP_IN_PORT; // RULE_04
      o_cycles = CYC_TWO;
    end else if (hit(i_opcode, OPC_IN_RX, MSK_ALL)) begin
      o_op = CID_OP_IN_RX; // RULE_05
    end else if (hit(i_opcode, OPC_JMPP, MSK_ALL)) begin
      o_op = CID_OP_JMPP; // RULE_11
      o_cycles = CYC_TWO;
    end else if (hit(i_opcode, OPC_JC, MSK_ALL)) begin
      o_op = CID_OP_JC; // RULE_07
    end else if (hit(i_opcode, OPC_JNC, MSK_ALL)) begin
      o_op = CID_OP_JNC; // RULE_12
    end else if (hit(i_opcode, OPC_JF0, MSK_ALL)) begin
      o_op = CID_OP_JUFA; // RULE_08
    end else if (hit(i_opcode, OPC_JF1, MSK_ALL)) begin
      o_op = CID_OP_JUFB; // RULE_09
    end else if (hit(i_opcode, OPC_JB, MSK_HI3)) begin
      o_op = CID_OP_JB; // RULE_06
    end else if (hit(i_opcode, OPC_JMP, MSK_HI3)) begin
      o_op = CID_OP_JMP; // RULE_10
    end
    // every jump except the indirect one is two cycles, two bytes
    if (o_op inside {CID_OP_JB, CID_OP_JC, CID_OP_JNC, CID_OP_JUFA, CID_OP_JUFB,
                     CID_OP_JMP}) begin
      o_cycles = CYC_TWO;
      o_bytes = BYTES_TWO;
    end
  end

endmodule // cid_decode

// ### core/cid_pkg.sv
package cid_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on the axi4-lite bus
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_ACC = 8'h0c;
  localparam logic [7:0] ADDR_PC = 8'h10;
  localparam logic [7:0] ADDR_RXBUF = 8'h14;
  localparam logic [7:0] ADDR_MEM_PTR = 8'h18;
  localparam logic [7:0] ADDR_DATA_MEM = 8'h1c;
  localparam logic [7:0] ADDR_PAGE_MEM = 8'h20;
  localparam logic [7:0] ADDR_WREG_BASE = 8'h40;
  localparam logic [7:0] ADDR_WREG_LAST = 8'h5c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FLD_OPERAND = 8;
  localparam int FLD_CARRY = 1;
  localparam int FLD_UFA = 2;
  localparam int FLD_UFB = 3;
  localparam int FLD_BANK = 4;
  localparam int FLD_RXFULL = 6;
  localparam int FLD_PC = 16;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [12:0] RST_PC = 13'h0000;
  localparam logic [1:0] RST_BANK = 2'h0;

  // ----------------------------------------------------------------
  // opcode patterns (match when (op & mask) == pattern)
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_INC_R = 8'h18;
  localparam logic [7:0] MSK_INC_R = 8'hf8;
  localparam logic [7:0] OPC_INC_IND = 8'h10;
  localparam logic [7:0] OPC_INCL = 8'h38;
  localparam logic [7:0] MSK_ONE_BIT = 8'hfe;
  localparam logic [7:0] OPC_IN_PORT = 8'he1;
  localparam logic [7:0] OPC_IN_RX = 8'he0;
  localparam logic [7:0] OPC_JMPP = 8'ha3;
  localparam logic [7:0] OPC_JB = 8'h12;
  localparam logic [7:0] OPC_JMP = 8'h04;
  localparam logic [7:0] MSK_HI3 = 8'h1f;
  localparam logic [7:0] OPC_JC = 8'hf6;
  localparam logic [7:0] OPC_JNC = 8'he6;
  localparam logic [7:0] OPC_JF0 = 8'hb6;
  localparam logic [7:0] OPC_JF1 = 8'h76;
  localparam logic [7:0] MSK_ALL = 8'hff;

  // ----------------------------------------------------------------
  // cycle and byte counts
  // ----------------------------------------------------------------
  localparam logic [1:0] CYC_ONE = 2'd1;
  localparam logic [1:0] CYC_TWO = 2'd2;
  localparam logic [12:0] BYTES_ONE = 13'd1;
  localparam logic [12:0] BYTES_TWO = 13'd2;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    CID_OP_NONE, CID_OP_INC_R, CID_OP_INC_IND, CID_OP_INCL, CID_OP_IN_PORT,
    CID_OP_IN_RX, CID_OP_JB, CID_OP_JC, CID_OP_JNC, CID_OP_JUFA, CID_OP_JUFB,
    CID_OP_JMP, CID_OP_JMPP
  } cid_op_t;

endpackage

// ### test/cid_core_monitor.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// port checks for the decode core
// ----------------------------------------------------------------
module cid_core_monitor
  import cid_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_rx_strobe,
  input wire logic o_rx_full,
  input wire logic o_busy,
  input wire logic [7:0] i_axi_awaddr,
  input wire logic i_axi_awvalid,
  input wire logic o_axi_awready,
  input wire logic i_axi_wvalid,
  input wire logic o_axi_wready,
  input wire logic [1:0] o_axi_bresp,
  input wire logic o_axi_bvalid,
  input wire logic i_axi_bready,
  input wire logic [7:0] i_axi_araddr,
  input wire logic i_axi_arvalid,
  input wire logic o_axi_arready,
  input wire logic [31:0] o_axi_rdata,
  input wire logic [1:0] o_axi_rresp,
  input wire logic o_axi_rvalid,
  input wire logic i_axi_rready
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  // both write channels taken at one edge; read address mapped
  logic wr_take;
  logic rd_mapped;
  assign wr_take = i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready;
  assign rd_mapped = (i_axi_araddr[1:0] == 2'b00) && ((i_axi_araddr <= ADDR_PAGE_MEM) ||
    (i_axi_araddr >= ADDR_WREG_BASE && i_axi_araddr <= ADDR_WREG_LAST));

  chk_busy_start: assert property (wr_take && i_axi_awaddr == ADDR_INSTR && !o_busy |=> ##1 o_busy)
    else $error("instruction write did not start execution");
  chk_busy_span: assert property ($rose(o_busy) |-> ##[1:2] !o_busy)
    else $error("instruction ran longer than two cycles");
  chk_rx_set: assert property (i_rx_strobe |=> o_rx_full)
    else $error("receive strobe did not flag a full buffer");
  chk_rx_clear: assert property ($fell(o_rx_full) |-> $fell(o_busy))
    else $error("receive full cleared outside an instruction commit");
  chk_wr_answer: assert property (wr_take |=> ##1 o_axi_bvalid)
    else $error("write response late");
  chk_b_hold: assert property (o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid && $stable(o_axi_bresp))
    else $error("write response dropped before handshake");
  chk_rd_answer: assert property (i_axi_arvalid && o_axi_arready |=> o_axi_rvalid)
    else $error("read data late");
  chk_r_hold: assert property (o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata))
    else $error("read data changed before handshake");
  chk_rd_refuse: assert property (i_axi_arvalid && o_axi_arready && !rd_mapped
    |=> o_axi_rresp == RESP_SLVERR && o_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_aw_block: assert property (i_axi_awvalid && o_axi_awready |=> !o_axi_awready)
    else $error("write address accepted twice");
endmodule // cid_core_monitor

bind cid_core cid_core_monitor u_cid_core_monitor (.*);

// ### test/tb_top.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// register-level bench for the decode core
// ----------------------------------------------------------------
module tb_top;
  import cid_pkg::*;

  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_port_data = 8'ha5;
  logic [7:0] i_rx_data = 8'h00;
  logic i_rx_strobe = 1'b0;
  logic [7:0] i_axi_awaddr = 8'h00, i_axi_araddr = 8'h00;
  logic [31:0] i_axi_wdata = 32'h0;
  logic [3:0] i_axi_wstrb = 4'hf;
  logic i_axi_awvalid = 1'b0, i_axi_wvalid = 1'b0, i_axi_bready = 1'b0;
  logic i_axi_arvalid = 1'b0, i_axi_rready = 1'b0;
  logic [7:0] o_acc;
  logic [12:0] o_pc;
  logic o_rx_full, o_busy, o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
  logic [1:0] o_axi_bresp, o_axi_rresp, rd_resp;
  logic [31:0] o_axi_rdata, rd_val;
  logic [7:0] v;
  int n_fail = 0;
  int n_checks = 0;
  int busy_cnt = 0;

  always #2 i_ref_clk = ~i_ref_clk;

  // busy cycles so far; an op's length is a difference
  always @(posedge i_ref_clk) if (o_busy === 1'b1) busy_cnt <= busy_cnt + 1;

  cid_core u_cid_core (.i_ref_clk, .i_rst_n, .i_port_data, .i_rx_data, .i_rx_strobe, .o_acc,
    .o_pc, .o_rx_full, .o_busy, .i_axi_awaddr, .i_axi_awvalid, .o_axi_awready, .i_axi_wdata,
    .i_axi_wstrb, .i_axi_wvalid, .o_axi_wready, .o_axi_bresp, .o_axi_bvalid, .i_axi_bready,
    .i_axi_araddr, .i_axi_arvalid, .o_axi_arready, .o_axi_rdata, .o_axi_rresp, .o_axi_rvalid,
    .i_axi_rready);

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // ready stands from the start; only the watchdog ends a wait
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] e = RESP_OKAY);
    @(posedge i_ref_clk);
    i_axi_awaddr <= a;
    i_axi_wdata <= d;
    i_axi_awvalid <= 1'b1;
    i_axi_wvalid <= 1'b1;
    i_axi_bready <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      if (o_axi_awready === 1'b1) i_axi_awvalid <= 1'b0;
      if (o_axi_wready === 1'b1) i_axi_wvalid <= 1'b0;
    end while (o_axi_bvalid !== 1'b1);
    i_axi_bready <= 1'b0;
    chk("write resp", 32'(e), 32'(o_axi_bresp));
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] e = RESP_OKAY);
    @(posedge i_ref_clk);
    i_axi_araddr <= a;
    i_axi_arvalid <= 1'b1;
    i_axi_rready <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      if (o_axi_arready === 1'b1) i_axi_arvalid <= 1'b0;
    end while (o_axi_rvalid !== 1'b1);
    rd_val = o_axi_rdata;
    rd_resp = o_axi_rresp;
    i_axi_rready <= 1'b0;
    chk("read resp", 32'(e), 32'(rd_resp));
  endtask

  // one instruction and its length
  task automatic run(input logic [7:0] op, input logic [7:0] opd, input int ncyc);
    int c0;
    c0 = busy_cnt;
    axi_wr(ADDR_INSTR, {16'h0, opd, op});
    for (int k = 0; k < 10 && o_busy !== 1'b0; k++) @(posedge i_ref_clk);
    chk("cycles", 32'(ncyc), 32'(busy_cnt - c0));
  endtask

  task automatic jcase(input logic [7:0] op, input logic [7:0] opd, input logic [7:0] flg,
    input logic [7:0] acc, input logic [12:0] pc0, input logic [12:0] exp);
    axi_wr(ADDR_FLAGS, {24'h0, flg});
    axi_wr(ADDR_ACC, {24'h0, acc});
    axi_wr(ADDR_PC, {19'h0, pc0});
    run(op, opd, 2);
    axi_rd(ADDR_PC);
    chk("jump pc", {19'h0, exp}, rd_val);
    chk("pc pin", {19'h0, exp}, {19'h0, o_pc});
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    axi_rd(ADDR_STATUS);
    chk("status reset", 32'h0, rd_val);
    axi_rd(8'h30, RESP_SLVERR);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rd_resp});
    chk("unmapped data", 32'h0, rd_val);
    axi_wr(8'h30, 32'h0, RESP_SLVERR);
    // every register, register 1 wrapping from ff to 00
    for (int r = 0; r < 8; r++) begin
      v = 8'hfe + 8'(r);
      axi_wr(ADDR_WREG_BASE + 8'(4 * r), {24'h0, v});
      axi_wr(ADDR_PC, 32'h0);
      run(OPC_INC_R | 8'(r), 8'h00, 1);
      axi_rd(ADDR_WREG_BASE + 8'(4 * r));
      chk("reg inc", {24'h0, v + 8'h01}, rd_val);
      axi_rd(ADDR_STATUS);
      chk("reg carry", {31'h0, v == 8'hff}, {31'h0, rd_val[FLD_CARRY]});
      chk("pc step", 32'h1, {19'h0, rd_val[28:16]});
    end
    for (int r = 0; r < 2; r++) begin
      axi_wr(ADDR_MEM_PTR, 32'h21 + r);
      axi_wr(ADDR_DATA_MEM, (r == 0) ? 32'hff : 32'h41);
      axi_wr(ADDR_WREG_BASE + 8'(4 * r), 32'h21 + r);
      run(OPC_INC_IND | 8'(r), 8'h00, 1);
      axi_rd(ADDR_DATA_MEM);
      chk("mem inc", (r == 0) ? 32'h0 : 32'h42, rd_val);
      axi_rd(ADDR_STATUS);
      chk("mem carry", 32'(r == 0), {31'h0, rd_val[FLD_CARRY]});
    end
    // pair p is registers 4p and 4p+1; all flags set first
    axi_wr(ADDR_FLAGS, 32'h3e);
    for (int p = 0; p < 2; p++) begin
      axi_wr(ADDR_WREG_BASE + 8'(16 * p), 32'hff);
      axi_wr(ADDR_WREG_BASE + 8'(16 * p + 4), 32'h12);
      run(OPC_INCL | 8'(p), 8'h00, 1);
      axi_rd(ADDR_WREG_BASE + 8'(16 * p));
      chk("pair low", 32'h0, rd_val);
      axi_rd(ADDR_WREG_BASE + 8'(16 * p + 4));
      chk("pair high", 32'h13, rd_val);
      axi_rd(ADDR_FLAGS);
      chk("pair flags", 32'h3e, rd_val);
    end
    run(OPC_IN_PORT, 8'h00, 2);
    axi_rd(ADDR_ACC);
    chk("port acc", 32'ha5, rd_val);
    chk("acc pin", 32'ha5, {24'h0, o_acc});
    @(posedge i_ref_clk);
    i_rx_data <= 8'h3c;
    i_rx_strobe <= 1'b1;
    @(posedge i_ref_clk);
    i_rx_strobe <= 1'b0;
    @(posedge i_ref_clk);
    chk("rx full", 32'h1, {31'h0, o_rx_full});
    run(OPC_IN_RX, 8'h00, 1);
    chk("rx cleared", 32'h0, {31'h0, o_rx_full});
    axi_rd(ADDR_ACC);
    chk("rx acc", 32'h3c, rd_val);
    // start at a page's last word so the skip crosses the page
    for (int b = 0; b < 8; b++) begin
      jcase(8'(b << 5) | OPC_JB, 8'h3c, 8'h00, 8'h01 << b, 13'h12fe, 13'h123c);
      jcase(8'(b << 5) | OPC_JB, 8'h3c, 8'h00, ~(8'h01 << b), 13'h12fe, 13'h1300);
    end
    jcase(OPC_JC, 8'h3c, 8'h02, 8'h00, 13'h12fe, 13'h123c);
    jcase(OPC_JC, 8'h3c, 8'h3c, 8'h00, 13'h12fe, 13'h1300);
    jcase(OPC_JNC, 8'h3c, 8'h3c, 8'h00, 13'h12fe, 13'h123c);
    jcase(OPC_JNC, 8'h3c, 8'h02, 8'h00, 13'h12fe, 13'h1300);
    jcase(OPC_JF0, 8'h3c, 8'h04, 8'h00, 13'h12fe, 13'h123c);
    jcase(OPC_JF0, 8'h3c, 8'h0a, 8'h00, 13'h12fe, 13'h1300);
    jcase(OPC_JF1, 8'h3c, 8'h08, 8'h00, 13'h12fe, 13'h123c);
    jcase(OPC_JF1, 8'h3c, 8'h06, 8'h00, 13'h12fe, 13'h1300);
    jcase(8'ha4, 8'ha7, 8'h20, 8'h00, 13'h0010, 13'h15a7);
    axi_wr(ADDR_MEM_PTR, 32'h80);
    axi_wr(ADDR_PAGE_MEM, 32'h5b);
    jcase(OPC_JMPP, 8'h00, 8'h00, 8'h80, 13'h0a40, 13'h0a5b);
    end_of_test();
  end

  // watchdog, far above the tests' length
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_fail++;
    end_of_test();
  end
endmodule // tb_top
